// ===== logic/pmcm_manager.v
// Power mode state machine, clock gating and clock prescalers
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "pmcm_defs.vh"
module pmcm_manager #(
  parameter AUX_W = 4
) (
  input wire i_clock, // Main clock
  input wire i_reset_n, // Asynchronous reset, active low
  input wire [`PMCM_ADDR_W-1:0] i_addr, // Register address
  input wire [7:0] i_wdata, // Write data
  input wire i_wr, // Write strobe
  input wire i_rd, // Read strobe
  output reg [7:0] o_rdata, // Read data, cycle after strobe
  input wire i_wait, // Wait instruction executed, pulse
  input wire i_irq, // Interrupt request
  input wire i_wake, // Hardware wake-up event (async)
  input wire i_radio_sleep, // Radio link controller sleeping (async)
  input wire i_low_osc_ok, // Low-frequency oscillator stable (async)
  input wire i_main_osc_ok, // Main oscillator stable (async)
  input wire i_pll_ok, // PLL stable (async)
  output reg o_cpu_stall, // CPU holds off issuing instructions
  output reg [1:0] o_mode, // Current power mode
  output reg [1:0] o_sys_src, // System clock source
  output reg o_main_osc_en, // Main oscillator enable
  output reg o_pll_en, // PLL enable
  output reg o_low_osc_en, // Low-frequency oscillator enable
  output reg o_slow_clk, // Slow clock from main clock
  output reg o_slow_run, // Slow clock run flag, high outside Halt (timer, watchdog)
  output reg o_aux1_clk, // Aux clock one (radio, audio)
  output reg o_aux2_clk, // Aux clock two (codec, converter)
  output reg o_usb_clk_en // PLL clock gate for USB
);

  // Divider output from a count and divisor, high for the first half of the period (the shorter half when odd), always high at divisor zero
  function div_high;
    input [AUX_W-1:0] cnt;
    input [AUX_W-1:0] div;
    begin
      div_high = ({1'b0, cnt} < (({1'b0, div} + 1'b1) >> 1)) || (div == {AUX_W{1'b0}});
    end
  endfunction

  // Two-stage synchronisers for foreign inputs
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg wake_prev_q;
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      wake_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {i_wake, i_radio_sleep, i_low_osc_ok, i_main_osc_ok, i_pll_ok};
      sync2_q <= sync1_q;
      wake_prev_q <= sync2_q[4]; // Wake history for edge detect
    end
  end
  wire wake_s = sync2_q[4];
  wire sleep_s = sync2_q[3];
  wire low_ok_s = sync2_q[2];
  wire main_ok_s = sync2_q[1];
  wire pll_ok_s = sync2_q[0];

  // Register decode
  wire wr_ctrl = i_wr && (i_addr == `PMCM_OFS_CTRL);
  wire wr_slow = i_wr && (i_addr == `PMCM_OFS_SLOW);
  wire wr_aux = i_wr && (i_addr == `PMCM_OFS_AUX);
  wire wr_clk = i_wr && (i_addr == `PMCM_OFS_CLK);

  reg [7:0] ctrl_q;
  reg [7:0] slow_div_q;
  reg [7:0] aux_div_q;
  reg [7:0] clk_q;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg pend_q;
  reg wake_q;

  wire in_low = (mode_q == `PMCM_MODE_PSAVE) || (mode_q == `PMCM_MODE_IDLE);
  wire req_any = i_wdata[`PMCM_B_PSAVE] | i_wdata[`PMCM_B_IDLE] | i_wdata[`PMCM_B_HALT];
  wire pll_pwd = clk_q[`PMCM_B_PLL_PWD];
  wire wake_hit = wake_s && !wake_prev_q; // Rising edge only, a held level acts once

  // Target mode from the stored mode flags, Halt first
  wire [1:0] target = ctrl_q[`PMCM_B_HALT] ? `PMCM_MODE_HALT :
                      ctrl_q[`PMCM_B_IDLE] ? `PMCM_MODE_IDLE :
                      ctrl_q[`PMCM_B_PSAVE] ? `PMCM_MODE_PSAVE : `PMCM_MODE_ACTIVE;
  // Pending request goes at once, or at the wait pulse when the wait bit is set
  wire go_low = low_ok_s && (target != `PMCM_MODE_ACTIVE) &&
                pend_q && (!ctrl_q[`PMCM_B_WBPS] || i_wait);
  wire act_ready = main_ok_s && (pll_ok_s || pll_pwd);

  // Prescaler registers and clock control
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      slow_div_q <= `PMCM_RST_SLOW;
      aux_div_q <= `PMCM_RST_AUX;
      clk_q <= `PMCM_RST_CLK;
    end
    else
    begin
      if (wr_slow)
        slow_div_q <= i_wdata;
      if (wr_aux)
        aux_div_q <= i_wdata;
      if (wr_clk)
        clk_q <= i_wdata & 8'h03;
    end
  end

  // Mode state machine
  always @*
  begin
    mode_d = mode_q;
    case (mode_q)
      `PMCM_MODE_ACTIVE:
        if (go_low)
          mode_d = target;
      `PMCM_MODE_PSAVE, `PMCM_MODE_IDLE:
        if (wake_q && act_ready)
          mode_d = `PMCM_MODE_ACTIVE;
      `PMCM_MODE_HALT:
        if (wake_q && main_ok_s)
          mode_d = `PMCM_MODE_ACTIVE;
      default:
        mode_d = `PMCM_MODE_ACTIVE;
    endcase
  end

  // Control register, pending entry and latched wake
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mode_q <= `PMCM_MODE_ACTIVE;
      ctrl_q <= `PMCM_RST_CTRL;
      pend_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      // Wake is held until the return to Active completes
      if (mode_d == `PMCM_MODE_ACTIVE && mode_q != `PMCM_MODE_ACTIVE)
        wake_q <= 1'b0;
      else if (wake_hit && mode_q != `PMCM_MODE_ACTIVE)
        wake_q <= 1'b1;
      if (wr_ctrl)
        pend_q <= req_any && (mode_q == `PMCM_MODE_ACTIVE);
      else if (mode_d != `PMCM_MODE_ACTIVE || wake_hit)
        pend_q <= 1'b0;
      // A software write wins over a wake clear in the same cycle
      if (wr_ctrl)
        ctrl_q <= i_wdata;
      else if (wake_hit)
      begin
        ctrl_q[`PMCM_B_PSAVE] <= 1'b0;
        ctrl_q[`PMCM_B_IDLE] <= 1'b0;
        ctrl_q[`PMCM_B_MAIN_OFF] <= 1'b0;
        ctrl_q[`PMCM_B_PLL_OFF] <= 1'b0;
      end
      else if (mode_q == `PMCM_MODE_HALT && mode_d == `PMCM_MODE_ACTIVE)
        ctrl_q[`PMCM_B_HALT] <= 1'b0;
      if (!wr_ctrl && mode_q != `PMCM_MODE_ACTIVE && mode_d == `PMCM_MODE_ACTIVE)
      begin
        ctrl_q[`PMCM_B_GATE_MAIN] <= 1'b0;
        ctrl_q[`PMCM_B_GATE_PLL] <= 1'b0;
      end
    end
  end

  // Source enables for the next cycle
  reg main_en_d;
  reg pll_en_d;
  reg [1:0] src_d;
  always @*
  begin
    main_en_d = 1'b1;
    pll_en_d = 1'b1;
    src_d = clk_q[`PMCM_B_SYSPLL] ? `PMCM_SRC_PLL : `PMCM_SRC_MAIN;
    case (mode_q)
      `PMCM_MODE_ACTIVE:
      begin
        main_en_d = 1'b1;
        pll_en_d = 1'b1;
      end
      `PMCM_MODE_PSAVE, `PMCM_MODE_IDLE:
      begin
        // Disable bits override radio gating
        main_en_d = !(ctrl_q[`PMCM_B_MAIN_OFF] || (ctrl_q[`PMCM_B_GATE_MAIN] && sleep_s));
        pll_en_d = !(ctrl_q[`PMCM_B_PLL_OFF] || (ctrl_q[`PMCM_B_GATE_PLL] && sleep_s));
        src_d = (mode_q == `PMCM_MODE_PSAVE) ? `PMCM_SRC_SLOW : `PMCM_SRC_NONE;
      end
      `PMCM_MODE_HALT:
      begin
        // Oscillator restarts only once a wake is latched, else Halt never ends
        main_en_d = wake_q;
        pll_en_d = 1'b0;
        src_d = `PMCM_SRC_NONE;
      end
      default:
      begin
        main_en_d = 1'b1;
        pll_en_d = 1'b1;
      end
    endcase
    if (pll_pwd)
    begin
      pll_en_d = 1'b0;
      if (src_d == `PMCM_SRC_PLL)
        src_d = `PMCM_SRC_MAIN;
    end
  end

  // Registered outputs for clock control and CPU stall
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cpu_stall <= 1'b0;
      o_mode <= `PMCM_MODE_ACTIVE;
      o_sys_src <= `PMCM_SRC_MAIN;
      o_main_osc_en <= 1'b1;
      o_pll_en <= 1'b1;
      o_low_osc_en <= 1'b1;
      o_usb_clk_en <= 1'b0;
      o_slow_run <= 1'b1;
    end
    else
    begin
      if (i_irq || wake_hit)
        o_cpu_stall <= 1'b0;
      else if (i_wait)
        o_cpu_stall <= 1'b1;
      o_mode <= mode_q;
      o_sys_src <= src_d;
      o_main_osc_en <= main_en_d;
      o_pll_en <= pll_en_d;
      o_low_osc_en <= 1'b1;
      o_usb_clk_en <= pll_en_d && pll_ok_s;
      o_slow_run <= (mode_q != `PMCM_MODE_HALT);
    end
  end

  // Slow clock divider, toggles every divisor plus one cycles
  reg [7:0] slow_cnt_q;
  reg [7:0] slow_cur_q;
  wire slow_on = (mode_q != `PMCM_MODE_HALT) && main_en_d;
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      slow_cnt_q <= 8'h00;
      slow_cur_q <= `PMCM_RST_SLOW;
      o_slow_clk <= 1'b0;
    end
    else if (!slow_on)
    begin
      slow_cnt_q <= 8'h00;
      slow_cur_q <= slow_div_q;
    end
    else if (slow_cnt_q >= slow_cur_q)
    begin
      slow_cnt_q <= 8'h00;
      o_slow_clk <= ~o_slow_clk;
      if (o_slow_clk)
        slow_cur_q <= slow_div_q;
    end
    else
      slow_cnt_q <= slow_cnt_q + 8'h01;
  end

  // Aux dividers, divide by field plus one
  wire aux_on = (mode_q != `PMCM_MODE_HALT) && main_en_d;
  wire [2*AUX_W-1:0] aux_field = {aux_div_q[7:4], aux_div_q[3:0]};
  wire [1:0] aux_out;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_aux
      reg [AUX_W-1:0] cnt_q;
      reg [AUX_W-1:0] cur_q;
      reg out_q;
      wire [AUX_W-1:0] nxt = (cnt_q >= cur_q) ? {AUX_W{1'b0}} : cnt_q + 1'b1;
      always @(posedge i_clock or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          cnt_q <= {AUX_W{1'b0}};
          cur_q <= {AUX_W{1'b1}};
          out_q <= 1'b0;
        end
        else if (!aux_on)
        begin
          cnt_q <= {AUX_W{1'b0}};
          cur_q <= aux_field[g*AUX_W +: AUX_W];
          out_q <= 1'b0;
        end
        else
        begin
          cnt_q <= nxt;
          if (cnt_q >= cur_q)
            cur_q <= aux_field[g*AUX_W +: AUX_W];
          out_q <= div_high(nxt, (cnt_q >= cur_q) ? aux_field[g*AUX_W +: AUX_W] : cur_q);
        end
      end
      assign aux_out[g] = out_q;
    end
  endgenerate

  // Aux outputs, index 1 is the high field
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_aux1_clk <= 1'b0;
      o_aux2_clk <= 1'b0;
    end
    else
    begin
      o_aux1_clk <= aux_out[1];
      o_aux2_clk <= aux_out[0];
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= 8'h00;
    else if (!i_rd)
      o_rdata <= 8'h00;
    else
    begin
      case (i_addr)
        `PMCM_OFS_CTRL: o_rdata <= ctrl_q;
        `PMCM_OFS_STAT: o_rdata <= {5'h00, pll_ok_s || !o_pll_en, main_ok_s, low_ok_s};
        `PMCM_OFS_SLOW: o_rdata <= slow_div_q;
        `PMCM_OFS_AUX: o_rdata <= aux_div_q;
        `PMCM_OFS_CLK: o_rdata <= {2'h0, mode_q, 2'h0, clk_q[1:0]};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ===== logic/pmcm_defs.vh
// Constants for the power mode and clock manager
`ifndef PMCM_DEFS_VH
`define PMCM_DEFS_VH
`define PMCM_ADDR_W 24
`define PMCM_OFS_CTRL 24'hFFFC60
`define PMCM_OFS_STAT 24'hFFFC62
`define PMCM_OFS_SLOW 24'hFFFC40
`define PMCM_OFS_AUX 24'hFFFC42
`define PMCM_OFS_CLK 24'hFFFC44
`define PMCM_RST_SLOW 8'hB6
`define PMCM_RST_AUX 8'hFF
`define PMCM_RST_CTRL 8'h00
`define PMCM_RST_CLK 8'h00
`define PMCM_B_PSAVE 0
`define PMCM_B_IDLE 1
`define PMCM_B_HALT 2
`define PMCM_B_WBPS 3
`define PMCM_B_MAIN_OFF 4
`define PMCM_B_PLL_OFF 5
`define PMCM_B_GATE_MAIN 6
`define PMCM_B_GATE_PLL 7
`define PMCM_B_PLL_PWD 0
`define PMCM_B_SYSPLL 1
`define PMCM_MODE_ACTIVE 2'h0
`define PMCM_MODE_PSAVE 2'h1
`define PMCM_MODE_IDLE 2'h2
`define PMCM_MODE_HALT 2'h3
`define PMCM_SRC_MAIN 2'h0
`define PMCM_SRC_PLL 2'h1
`define PMCM_SRC_SLOW 2'h2
`define PMCM_SRC_NONE 2'h3
`endif

// ===== sim/pmcm_osc_model.sv
// Oscillator and PLL start-up model facing the manager
`timescale 1ns/1ps
module pmcm_osc_model #(
  parameter START = 16
) (
  input wire logic i_clock, // Clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic i_main_en, // Main osc enable
  input wire logic i_pll_en, // PLL enable
  input wire logic i_low_avail, // Low osc present
  output logic o_main_ok, // Main osc stable
  output logic o_pll_ok, // PLL stable
  output logic o_low_ok // Low osc stable
);
  localparam [7:0] ST = START;
  logic [7:0] main_q;
  logic [7:0] pll_q;
  // Settling count after each enable, lost at once on disable
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      main_q <= 8'h00;
      pll_q <= 8'h00;
    end
    else
    begin
      main_q <= !i_main_en ? 8'h00 : (main_q < ST) ? main_q + 8'h01 : main_q;
      pll_q <= !i_pll_en ? 8'h00 : (pll_q < ST) ? pll_q + 8'h01 : pll_q;
    end
  end
  // Stable flags; low osc only fails when the bench removes it
  assign o_main_ok = (main_q == ST);
  assign o_pll_ok = (pll_q == ST);
  assign o_low_ok = i_low_avail;
endmodule

// ===== sim/pmcm_checker.sv
// Port assertions for the power mode manager
`timescale 1ns/1ps
`include "pmcm_defs.vh"
module pmcm_checker #(
  parameter AUX_W = 4
) (
  input wire i_clock, // Clock
  input wire i_reset_n, // Reset
  input wire i_rd, // Read strobe
  input wire [7:0] o_rdata, // Read data
  input wire i_wait, // Wait pulse
  input wire i_irq, // Interrupt
  input wire i_wake, // Wake event
  input wire o_cpu_stall, // CPU stall
  input wire [1:0] o_mode, // Mode
  input wire [1:0] o_sys_src, // Clock source
  input wire o_main_osc_en, // Main enable
  input wire o_pll_en, // PLL enable
  input wire o_low_osc_en, // Low enable
  input wire o_slow_run, // Slow running
  input wire o_usb_clk_en // USB gate
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Clock sources and enables per mode, CPU stall, wake return and read data
  low_osc_a: assert property (o_low_osc_en)
    else $error("low osc enable dropped");
  active_on_a: assert property (o_mode == `PMCM_MODE_ACTIVE && $past(o_mode) == `PMCM_MODE_ACTIVE |-> o_main_osc_en)
    else $error("main osc off in active");
  psave_src_a: assert property (o_mode == `PMCM_MODE_PSAVE |-> o_sys_src == `PMCM_SRC_SLOW)
    else $error("power save not on slow clock");
  idle_src_a: assert property (o_mode == `PMCM_MODE_IDLE |-> o_sys_src == `PMCM_SRC_NONE)
    else $error("idle system clock running");
  slow_run_a: assert property (o_mode != `PMCM_MODE_HALT && $past(o_mode) != `PMCM_MODE_HALT |-> o_slow_run)
    else $error("slow clock stopped outside halt");
  halt_entry_a: assert property ($changed(o_mode) && o_mode == `PMCM_MODE_HALT |->
    !o_main_osc_en && !o_pll_en && !o_slow_run && o_sys_src == `PMCM_SRC_NONE)
    else $error("halt left clocks on");
  usb_gate_a: assert property (!o_pll_en && !$past(o_pll_en) |-> !o_usb_clk_en)
    else $error("usb clock without pll");
  stall_set_a: assert property (i_wait && !i_irq |=> o_cpu_stall)
    else $error("wait did not stall");
  stall_clr_a: assert property (i_irq |=> !o_cpu_stall)
    else $error("interrupt did not release stall");
  wake_ret_a: assert property ($rose(i_wake) && o_mode != `PMCM_MODE_ACTIVE |-> ##[1:120] o_mode == `PMCM_MODE_ACTIVE)
    else $error("wake did not return to active");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  // Main scenarios reached
  c_psave: cover property (o_mode == `PMCM_MODE_PSAVE);
  c_idle_stall: cover property (o_mode == `PMCM_MODE_IDLE && o_cpu_stall);
  c_halt: cover property (o_mode == `PMCM_MODE_HALT);
endmodule
bind pmcm_manager pmcm_checker #(.AUX_W(AUX_W)) u_pmcm_checker (.*);

// ===== sim/testbench.sv
// Self-checking bench for the power mode manager
`timescale 1ns/1ps
`include "pmcm_defs.vh"
module testbench;
  localparam [23:0] CTRL = `PMCM_OFS_CTRL;
  logic i_clock, i_reset_n, i_wr, i_rd, i_wait, i_irq, i_wake, i_radio_sleep, low_avail;
  logic i_low_osc_ok, i_main_osc_ok, i_pll_ok, o_cpu_stall, o_main_osc_en, o_pll_en, o_low_osc_en;
  logic o_slow_clk, o_slow_run, o_aux1_clk, o_aux2_clk, o_usb_clk_en;
  logic [23:0] i_addr;
  logic [7:0] i_wdata, o_rdata, p;
  logic [1:0] o_mode, o_sys_src;
  logic [47:0] rows [5];
  int error_cnt, checked;
  pmcm_manager #(.AUX_W(4)) u_pmcm_manager (.*);
  pmcm_osc_model u_pmcm_osc_model (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_main_en(o_main_osc_en),
    .i_pll_en(o_pll_en), .i_low_avail(low_avail), .o_main_ok(i_main_osc_ok), .o_pll_ok(i_pll_ok),
    .o_low_ok(i_low_osc_ok));
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register bus cycles
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, exp, what);
  endtask
  // One-cycle pulse on wait or interrupt
  task automatic pulse(input logic irq);
    @(posedge i_clock);
    i_wait <= !irq;
    i_irq <= irq;
    @(posedge i_clock);
    i_wait <= 1'b0;
    i_irq <= 1'b0;
    #1;
  endtask
  // Bounded wait for a mode
  task automatic wmode(input logic [1:0] m, input string what);
    for (int n = 0; n < 200 && o_mode !== m; n++)
    begin
      @(posedge i_clock);
      #1;
    end
    check({6'h00, o_mode}, {6'h00, m}, what);
  endtask
  task automatic wake_up(input string what);
    @(posedge i_clock);
    i_wake <= 1'b1;
    wmode(`PMCM_MODE_ACTIVE, what);
    i_wake <= 1'b0;
  endtask
  // Period between second and third rising edge of a divided clock
  task automatic meas(input int sel, output logic [7:0] per);
    logic prev;
    logic cur;
    int rises;
    prev = 1'b0;
    rises = 0;
    per = 8'h00;
    for (int n = 0; n < 800 && rises < 3; n++)
    begin
      @(posedge i_clock);
      #1;
      cur = (sel == 0) ? o_slow_clk : (sel == 1) ? o_aux1_clk : o_aux2_clk;
      per = per + 8'h01;
      if (cur === 1'b1 && prev === 1'b0)
      begin
        rises++;
        if (rises < 3)
          per = 8'h00;
      end
      prev = cur;
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // Hang guard
  initial
  begin
    #400000;
    error_cnt++;
    finish_test;
  end
  initial
  begin
    {i_reset_n, i_wr, i_rd, i_wait, i_irq, i_wake, i_radio_sleep} = 7'h00;
    {i_addr, i_wdata} = 32'h00000000;
    low_avail = 1'b1;
    // Address, reset value, write value, read-back value
    rows[0] = {`PMCM_OFS_SLOW, 8'hB6, 8'h5A, 8'h5A};
    rows[1] = {`PMCM_OFS_AUX, 8'hFF, 8'h3C, 8'h3C};
    rows[2] = {`PMCM_OFS_STAT, 8'h07, 8'hFF, 8'h07};
    rows[3] = {24'hFFFC50, 8'h00, 8'h12, 8'h00};
    rows[4] = {CTRL, 8'h00, 8'hF0, 8'hF0};
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (20) @(posedge i_clock);
    check({6'h00, o_mode}, 8'h00, "mode after reset");
    foreach (rows[i])
    begin
      rd(rows[i][47:24], rows[i][23:16], "reset value");
      wr(rows[i][47:24], rows[i][15:8]);
      rd(rows[i][47:24], rows[i][7:0], "read back");
    end
    check({6'h00, o_main_osc_en, o_pll_en}, 8'h03, "active ignores disables");
    meas(0, p);
    check(p, 8'hB6, "slow period");
    meas(1, p);
    check(p, 8'h04, "aux one period");
    meas(2, p);
    check(p, 8'h0D, "aux two period");
    wr(`PMCM_OFS_SLOW, 8'h00);
    meas(0, p);
    check(p, 8'h02, "slow period after reload");
    pulse(1'b0);
    check({7'h00, o_cpu_stall}, 8'h01, "stall on wait");
    pulse(1'b1);
    check({7'h00, o_cpu_stall}, 8'h00, "stall after irq");
    // PLL as system source, then PLL power down
    wr(`PMCM_OFS_CLK, 8'h02);
    repeat (2) @(posedge i_clock);
    #1;
    check({6'h00, o_sys_src}, 8'h01, "system clock from pll");
    wr(`PMCM_OFS_CLK, 8'h03);
    repeat (2) @(posedge i_clock);
    #1;
    check({3'h0, o_usb_clk_en, o_sys_src, o_main_osc_en, o_pll_en}, 8'h02, "pll power down");
    rd(`PMCM_OFS_CLK, 8'h03, "clock control");
    wr(`PMCM_OFS_CLK, 8'h00);
    // Low osc missing: entry held back until it returns
    low_avail <= 1'b0;
    repeat (3) @(posedge i_clock);
    wr(CTRL, 8'h01);
    repeat (10) @(posedge i_clock);
    check({6'h00, o_mode}, 8'h00, "entry without low osc");
    low_avail <= 1'b1;
    wmode(`PMCM_MODE_PSAVE, "power save entry");
    i_radio_sleep <= 1'b1;
    wr(CTRL, 8'h81);
    repeat (6) @(posedge i_clock);
    check({7'h00, o_pll_en}, 8'h00, "pll gated by radio sleep");
    i_radio_sleep <= 1'b0;
    wr(CTRL, 8'h51);
    repeat (6) @(posedge i_clock);
    check({6'h00, o_main_osc_en, o_pll_en}, 8'h01, "disable over gating");
    wake_up("wake from power save");
    rd(CTRL, 8'h00, "flags cleared by wake");
    // Deferred idle entry
    wr(CTRL, 8'h0A);
    repeat (5) @(posedge i_clock);
    check({6'h00, o_mode}, 8'h00, "idle before wait");
    pulse(1'b0);
    wmode(`PMCM_MODE_IDLE, "idle entry");
    check({6'h00, o_cpu_stall, o_slow_run}, 8'h03, "idle stall and slow clock");
    wake_up("wake from idle");
    // Halt stops every derived clock
    wr(CTRL, 8'h0C); // converter taken as already off
    pulse(1'b0);
    wmode(`PMCM_MODE_HALT, "halt entry");
    repeat (2) @(posedge i_clock);
    check({o_main_osc_en, o_pll_en, o_slow_run, o_usb_clk_en, o_aux1_clk, o_aux2_clk, o_low_osc_en}, 8'h01,
      "halt clocks");
    wake_up("wake from halt");
    rd(CTRL, 8'h08, "halt flag cleared"); // wait bit stays set
    finish_test;
  end
endmodule
